// file: core/ssel_params.svh
// constants for the stream channel selector: offsets, field positions, reset values
`ifndef SSEL_PARAMS_SVH
`define SSEL_PARAMS_SVH
// register byte addresses
`define SSEL_ADR_CTRL    8'h00
`define SSEL_ADR_SEL0    8'h04
`define SSEL_ADR_SEL1    8'h08
`define SSEL_ADR_SEL2    8'h0c
`define SSEL_ADR_SEL3    8'h10
`define SSEL_ADR_STAT    8'h14
// control register fields
`define SSEL_CTRL_INT    0
`define SSEL_CTRL_MD_LO  1
`define SSEL_CTRL_MD_HI  2
`define SSEL_CTRL_LOGIC  3
`define SSEL_CTRL_CSRC   4
`define SSEL_CTRL_STSIG  5
`define SSEL_CTRL_STSEL  6
`define SSEL_CTRL_FLW_LO 8
`define SSEL_CTRL_FLW_HI 10
`define SSEL_CTRL_CNT_LO 16
`define SSEL_CTRL_CNT_HI 21
`define SSEL_CTRL_WID_LO 24
`define SSEL_CTRL_WID_HI 29
// control reset: integer off, whole mode, 8-bit packed fields, 4 sub-fields of 8 bits
`define SSEL_CTRL_RST    32'h0804_0300
// selection register fields: channel, sub-field, comparison value
`define SSEL_SEL_CH_LO   0
`define SSEL_SEL_CH_HI   7
`define SSEL_SEL_SUB_LO  8
`define SSEL_SEL_SUB_HI  15
`define SSEL_SEL_CMP_LO  16
`define SSEL_SEL_CMP_HI  31
`define SSEL_SEL_RST     32'h0000_0000
// word geometry
`define SSEL_WORD_W      6'h20
`define SSEL_LG_MAX      3'h5
`endif

// file: core/ssel_pkg.sv
// types shared by the stream channel selector modules
package ssel_pkg;
  // extraction modes as coded in the control register
  typedef enum logic [1:0] {
    ssel_whole  = 2'h0,
    ssel_packed = 2'h1,
    ssel_sub    = 2'h2
  } ssel_mode_type;
  // buffer payload: store flag, four logic bits, four 32-bit values
  localparam int unsigned SSEL_PAY_W = 133;
endpackage

// file: core/ssel_buf_if.sv
// handshake bundle between the selector core and its two-entry output buffer
`timescale 1ns/1ps
interface ssel_buf_if #(parameter int unsigned W = 8);
  logic         push_valid;  // core offers a frame result
  logic         push_ready;  // buffer has room, registered
  logic [W-1:0] push_data;   // frame result
  logic         pop_valid;   // head entry present, registered
  logic         pop_ready;   // receiver takes the head
  logic [W-1:0] pop_data;    // head entry, registered
  modport src (output push_valid, output push_data, output pop_ready,
               input push_ready, input pop_valid, input pop_data);
  modport sink (input push_valid, input push_data, input pop_ready,
                output push_ready, output pop_valid, output pop_data);
endinterface

// file: core/ssel_buf2.sv
// two-entry buffer with registered valid, ready and data
`timescale 1ns/1ps
module ssel_buf2 (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ssel_buf_if.sink  bi
);
  logic [1:0]               cnt_ff;    // entries held
  logic [$bits(bi.push_data)-1:0] ent1_ff;   // second entry
  logic [1:0]               nxt_cnt;
  logic                     push;
  logic                     pop;
  logic                     ready_ff;
  logic                     valid_ff;
  logic [$bits(bi.push_data)-1:0] head_ff;

  assign push = bi.push_valid && ready_ff;
  assign pop  = valid_ff && bi.pop_ready;
  assign bi.push_ready = ready_ff;
  assign bi.pop_valid  = valid_ff;
  assign bi.pop_data   = head_ff;

  // occupancy after this edge
  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  // flags come from the next count so that they stay registered yet exact
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff   <= 2'h0;
      ready_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else begin
      cnt_ff   <= nxt_cnt;
      ready_ff <= (nxt_cnt != 2'h2);
      valid_ff <= (nxt_cnt != 2'h0);
    end
  end

  // head moves up on a pop; a new word fills the first free slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      head_ff <= '0;
      ent1_ff <= '0;
    end else begin
      if (pop) begin
        head_ff <= (cnt_ff == 2'h2) ? ent1_ff : bi.push_data;
        if (push) begin
          ent1_ff <= bi.push_data;
        end
      end else if (push) begin
        if (cnt_ff == 2'h0) begin
          head_ff <= bi.push_data;
        end else begin
          ent1_ff <= bi.push_data;
        end
      end
    end
  end
endmodule

// file: core/ssel_top.sv
// stream channel selector: frame word picker, field extraction, registers and buffer
// Operation
// - accept float or 32-bit integer frames
// - default: each output carries one whole channel
// - unpacking only for integer input streams
// - packed mode splits words into fields
// - sub-field mode picks channel and sub-field
// - packed logic output: field equals compare value
// - sub-field logic output: matches target code
// - selection changeable by software or control input
// - four outputs stored all together or none
// - output and selection recording enabled separately
`timescale 1ns/1ps
`include "ssel_params.svh"
module ssel_top #(
  parameter int unsigned NOUT = 4  // number of selected outputs
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic [3:0]   wb_sel_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [31:0]  in_data_i,
  input  wire logic         in_last_i,
  input  wire logic         ctl_valid_i,
  input  wire logic [1:0]   ctl_out_i,
  input  wire logic [7:0]   ctl_chan_i,
  input  wire logic [7:0]   ctl_sub_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [127:0] selected_channel_outputs_o,
  output logic      [3:0]   out_logic_o,
  output logic              out_store_o,
  output logic              rec_sel_valid_o,
  output logic      [31:0]  rec_sel_chan_o
);
  // software-visible state
  logic [31:0]            ctrl_ff;          // mode, widths, enables
  logic [31:0]            sel_ff [NOUT];    // per-output selection and compare value
  logic [31:0]            nxt_sel [NOUT];
  logic [7:0]             widx_ff;          // word position inside the current frame
  logic [7:0]             frm_ff;           // frames completed, wraps
  logic [31:0]            hold_ff [NOUT];   // last extracted value per output
  logic                   ack_ff;
  logic [31:0]            rdat_ff;
  logic                   rec_v_ff;
  logic [31:0]            rec_ch_ff;
  // derived per-output targets
  ssel_pkg::ssel_mode_type eff_mode;
  logic [2:0]             lw_c;             // log2 of packed field width
  logic [7:0]             tgt_word [NOUT];
  logic [13:0]            tgt_off  [NOUT];
  logic [5:0]             tgt_wid  [NOUT];
  logic                   tgt_ok   [NOUT];
  logic [31:0]            nxt_val  [NOUT];
  logic [NOUT-1:0]        hit;
  logic [NOUT-1:0]        lg_bit;
  logic                   in_fire;
  logic                   wb_req;
  logic                   wb_wr;
  logic                   sel_chg;
  logic [ssel_pkg::SSEL_PAY_W-1:0] pay;

  ssel_buf_if #(.W(ssel_pkg::SSEL_PAY_W)) bif ();

  // mask of the low wid bits, full word when wid reaches the word width
  function automatic logic [31:0] f_mask(input logic [5:0] wid);
    logic [32:0] one_sh;
    one_sh = 33'h1 << wid;
    f_mask = (wid >= `SSEL_WORD_W) ? 32'hffff_ffff : one_sh[31:0] - 32'h1;
  endfunction

  // pull a field out of a word; a disallowed field reads as zero
  function automatic logic [31:0] f_field(input logic [31:0] w, input logic [13:0] off,
                                          input logic [5:0] wid, input logic ok);
    f_field = ok ? ((w >> off) & f_mask(wid)) : 32'h0;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] f_merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    f_merge = r;
  endfunction

  assign in_fire = in_valid_i && in_ready_o;
  assign wb_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr   = wb_req && wb_we_i;

  // unpacking only when the stream is integer; float frames stay whole
  always_comb begin
    eff_mode = ssel_pkg::ssel_whole;
    if (ctrl_ff[`SSEL_CTRL_INT]) begin
      if (ctrl_ff[`SSEL_CTRL_MD_HI:`SSEL_CTRL_MD_LO] == ssel_pkg::ssel_packed) begin
        eff_mode = ssel_pkg::ssel_packed;
      end else if (ctrl_ff[`SSEL_CTRL_MD_HI:`SSEL_CTRL_MD_LO] == ssel_pkg::ssel_sub) begin
        eff_mode = ssel_pkg::ssel_sub;
      end
    end
    lw_c = (ctrl_ff[`SSEL_CTRL_FLW_HI:`SSEL_CTRL_FLW_LO] > `SSEL_LG_MAX) ?
           `SSEL_LG_MAX : ctrl_ff[`SSEL_CTRL_FLW_HI:`SSEL_CTRL_FLW_LO];
  end

  // per-output word position, bit offset and width of the wanted field
  always_comb begin
    for (int j = 0; j < NOUT; j++) begin
      tgt_word[j] = sel_ff[j][`SSEL_SEL_CH_HI:`SSEL_SEL_CH_LO];
      tgt_off[j]  = 14'h0;
      tgt_wid[j]  = `SSEL_WORD_W;
      tgt_ok[j]   = 1'b1;
      case (eff_mode)
        ssel_pkg::ssel_packed: begin
          // field n lives in word n/fpw at slot n%fpw, lowest bits first
          tgt_word[j] = sel_ff[j][`SSEL_SEL_CH_HI:`SSEL_SEL_CH_LO] >> (`SSEL_LG_MAX - lw_c);
          tgt_off[j]  = 14'((sel_ff[j][`SSEL_SEL_CH_HI:`SSEL_SEL_CH_LO]
                             & 8'((9'h1 << (`SSEL_LG_MAX - lw_c)) - 9'h1)) << lw_c);
          tgt_wid[j]  = 6'(7'h1 << lw_c);
        end
        ssel_pkg::ssel_sub: begin
          // sub-field index beyond the configured count yields zero
          // widen both factors first so that a large index times width keeps every bit
          tgt_off[j]  = 14'(sel_ff[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_SUB_LO])
                        * 14'(ctrl_ff[`SSEL_CTRL_WID_HI:`SSEL_CTRL_WID_LO]);
          tgt_wid[j]  = ctrl_ff[`SSEL_CTRL_WID_HI:`SSEL_CTRL_WID_LO];
          tgt_ok[j]   = sel_ff[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_SUB_LO]
                        < {2'h0, ctrl_ff[`SSEL_CTRL_CNT_HI:`SSEL_CTRL_CNT_LO]};
        end
        default: begin
          tgt_ok[j] = 1'b1;
        end
      endcase
    end
  end

  // capture the wanted field as its word passes; logic bit compares to the target
  always_comb begin
    for (int j = 0; j < NOUT; j++) begin
      hit[j]     = in_fire && (widx_ff == tgt_word[j]);
      nxt_val[j] = hit[j] ? f_field(in_data_i, tgt_off[j], tgt_wid[j], tgt_ok[j]) : hold_ff[j];
      // packed compares field to value, sub-field mode to the target code
      lg_bit[j]  = ctrl_ff[`SSEL_CTRL_LOGIC] && (eff_mode != ssel_pkg::ssel_whole)
                   && (nxt_val[j] == {16'h0, sel_ff[j][`SSEL_SEL_CMP_HI:`SSEL_SEL_CMP_LO]});
    end
  end

  // one store flag covers all four values of a frame, never a subset
  assign pay = {ctrl_ff[`SSEL_CTRL_STSIG], lg_bit,
                nxt_val[3], nxt_val[2], nxt_val[1], nxt_val[0]};
  assign bif.push_valid = in_fire && in_last_i;
  assign bif.push_data  = pay;
  assign bif.pop_ready  = out_ready_i;

  ssel_buf2 u_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bi    (bif)
  );

  // all words stall while the buffer is full; simpler than stalling only the last
  assign in_ready_o                 = bif.push_ready;
  assign out_valid_o                = bif.pop_valid;
  assign selected_channel_outputs_o = bif.pop_data[127:0];
  assign out_logic_o                = bif.pop_data[131:128];
  assign out_store_o                = bif.pop_data[132];

  // word position and frame counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      widx_ff <= 8'h0;
      frm_ff  <= 8'h0;
    end else if (in_fire) begin
      widx_ff <= in_last_i ? 8'h0 : widx_ff + 8'h1;
      if (in_last_i) begin
        frm_ff <= frm_ff + 8'h1;
      end
    end
  end

  // held field values keep the last capture between frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < NOUT; j++) begin
        hold_ff[j] <= 32'h0;
      end
    end else begin
      for (int j = 0; j < NOUT; j++) begin
        hold_ff[j] <= nxt_val[j];
      end
    end
  end

  // control register write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `SSEL_CTRL_RST;
    end else if (wb_wr && (wb_adr_i == `SSEL_ADR_CTRL)) begin
      ctrl_ff <= f_merge(ctrl_ff, wb_dat_i, wb_sel_i);
    end
  end

  // selection update: software owns channel and sub-field unless the control input does
  always_comb begin
    sel_chg = 1'b0;
    for (int j = 0; j < NOUT; j++) begin
      nxt_sel[j] = sel_ff[j];
      if (wb_wr && (wb_adr_i == `SSEL_ADR_SEL0 + 8'(j * 4))) begin
        nxt_sel[j] = f_merge(sel_ff[j], wb_dat_i, wb_sel_i);
        if (ctrl_ff[`SSEL_CTRL_CSRC]) begin
          nxt_sel[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_CH_LO] = sel_ff[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_CH_LO];
        end
      end
      if (ctrl_ff[`SSEL_CTRL_CSRC] && ctl_valid_i && (ctl_out_i == 2'(j))) begin
        nxt_sel[j][`SSEL_SEL_CH_HI:`SSEL_SEL_CH_LO]   = ctl_chan_i;
        nxt_sel[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_SUB_LO] = ctl_sub_i;
      end
      if (nxt_sel[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_CH_LO] != sel_ff[j][`SSEL_SEL_SUB_HI:`SSEL_SEL_CH_LO]) begin
        sel_chg = 1'b1;
      end
    end
  end

  // selection registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < NOUT; j++) begin
        sel_ff[j] <= `SSEL_SEL_RST;
      end
    end else begin
      for (int j = 0; j < NOUT; j++) begin
        sel_ff[j] <= nxt_sel[j];
      end
    end
  end

  // selection record strobe, independent of the signal store flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_v_ff  <= 1'b0;
      rec_ch_ff <= 32'h0;
    end else begin
      rec_v_ff  <= sel_chg && ctrl_ff[`SSEL_CTRL_STSEL];
      rec_ch_ff <= {nxt_sel[3][7:0], nxt_sel[2][7:0], nxt_sel[1][7:0], nxt_sel[0][7:0]};
    end
  end
  assign rec_sel_valid_o = rec_v_ff;
  assign rec_sel_chan_o  = rec_ch_ff;

  // bus slave: one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_req;
      if (wb_req) begin
        if (wb_adr_i == `SSEL_ADR_CTRL) begin
          rdat_ff <= ctrl_ff;
        end else if (wb_adr_i == `SSEL_ADR_SEL0) begin
          rdat_ff <= sel_ff[0];
        end else if (wb_adr_i == `SSEL_ADR_SEL1) begin
          rdat_ff <= sel_ff[1];
        end else if (wb_adr_i == `SSEL_ADR_SEL2) begin
          rdat_ff <= sel_ff[2];
        end else if (wb_adr_i == `SSEL_ADR_SEL3) begin
          rdat_ff <= sel_ff[3];
        end else if (wb_adr_i == `SSEL_ADR_STAT) begin
          rdat_ff <= {8'h0, frm_ff, widx_ff, 5'h0, eff_mode, !bif.push_ready};
        end else begin
          rdat_ff <= 32'h0;
        end
      end
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // checks
  sequence s_last_taken;
    in_valid_i && in_ready_o && in_last_i;
  endsequence

  property p_frame_out;
    @(posedge clk_i) disable iff (rst_i) s_last_taken |=> out_valid_o;
  endproperty
  a_frame_out: assert property (p_frame_out) else $error("frame end gave no output");

  property p_whole_cap;
    @(posedge clk_i) disable iff (rst_i)
      (hit[0] && eff_mode == ssel_pkg::ssel_whole) |=> (hold_ff[0] == $past(in_data_i));
  endproperty
  a_whole_cap: assert property (p_whole_cap) else $error("whole channel not captured");

  property p_float_whole;
    @(posedge clk_i) disable iff (rst_i) !ctrl_ff[`SSEL_CTRL_INT] |-> eff_mode == ssel_pkg::ssel_whole;
  endproperty
  a_float_whole: assert property (p_float_whole) else $error("float stream unpacked");

  property p_packed_w;
    @(posedge clk_i) disable iff (rst_i)
      (hit[0] && eff_mode == ssel_pkg::ssel_packed) |=> (hold_ff[0] >> $past(tgt_wid[0])) == 32'h0;
  endproperty
  a_packed_w: assert property (p_packed_w) else $error("packed field too wide");

  property p_sub_range;
    @(posedge clk_i) disable iff (rst_i)
      (hit[3] && eff_mode == ssel_pkg::ssel_sub && !tgt_ok[3]) |=> hold_ff[3] == 32'h0;
  endproperty
  a_sub_range: assert property (p_sub_range) else $error("absent sub-field not zero");

  property p_logic_pk;
    @(posedge clk_i) disable iff (rst_i)
      (s_last_taken and (bif.push_ready && !out_valid_o && eff_mode == ssel_pkg::ssel_packed))
      |=> out_logic_o[0] == ($past(ctrl_ff[`SSEL_CTRL_LOGIC])
          && (selected_channel_outputs_o[31:0] == {16'h0, $past(sel_ff[0][31:16])}));
  endproperty
  a_logic_pk: assert property (p_logic_pk) else $error("packed logic bit wrong");

  property p_logic_off;
    @(posedge clk_i) disable iff (rst_i)
      (bif.push_valid && (!ctrl_ff[`SSEL_CTRL_LOGIC] || eff_mode == ssel_pkg::ssel_whole))
      |-> bif.push_data[131:128] == 4'h0;
  endproperty
  a_logic_off: assert property (p_logic_off) else $error("logic bit while disabled");

  property p_ctl_sel;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_ff[`SSEL_CTRL_CSRC] && ctl_valid_i && ctl_out_i == 2'h2)
      |=> sel_ff[2][7:0] == $past(ctl_chan_i) ##1 rec_sel_chan_o[23:16] == sel_ff[2][7:0];
  endproperty
  a_ctl_sel: assert property (p_ctl_sel) else $error("control input selection lost");

  property p_rec_sel;
    @(posedge clk_i) disable iff (rst_i)
      (sel_chg && ctrl_ff[`SSEL_CTRL_STSEL]) |=> rec_sel_valid_o ##1 (!rec_sel_valid_o || $past(sel_chg));
  endproperty
  a_rec_sel: assert property (p_rec_sel) else $error("selection record missed");
endmodule

// file: bench/ssel_sink_model.sv
// downstream receiver model for the selector's frame results
`timescale 1ns/1ps
module ssel_sink_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         stall_i,
  input  wire logic         slow_i,
  input  wire logic         valid_i,
  output logic              ready_o,
  input  wire logic [127:0] data_i,
  input  wire logic [3:0]   logic_i,
  input  wire logic         store_i
);
  logic [132:0] got_q[$];  // accepted results, oldest first
  logic         tick_ff;   // pacing phase for the slow receiver
  // pacing phase: a slow receiver only accepts on alternate cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
    end
  end
  // a stalled receiver never accepts, so the buffer must hold results
  assign ready_o = ~rst_i & ~stall_i & (~slow_i | tick_ff);
  // capture: the store flag records all four values as one unit
  // plain always: the bench pops this queue, so it has two writers
  always @(posedge clk_i) begin
    if (!rst_i && valid_i && ready_o) begin
      got_q.push_back({store_i, logic_i, data_i});
    end
  end
endmodule

// file: bench/test_stream_channel_selector.sv
// self-checking bench for the stream channel selector
`timescale 1ns/1ps
module test_stream_channel_selector;
  logic         clk_i, rst_i;         // clock and reset
  logic         wb_cyc, wb_stb, wb_we; // bus request
  logic [7:0]   wb_adr;                // bus address
  logic [31:0]  wb_wdat, wb_rdat, rd;  // bus data, last read
  logic [3:0]   wb_sel;                // byte enables
  logic         wb_ack;                // bus answer
  logic         in_valid, in_ready, in_last;
  logic [31:0]  in_data;               // stream word
  logic         ctl_valid;             // control input pulse
  logic [1:0]   ctl_out;
  logic [7:0]   ctl_chan, ctl_sub;
  logic         out_valid, out_ready, out_store, rec_valid, stall, slow;
  logic [127:0] out_data;              // four selected values
  logic [3:0]   out_logic;
  logic [31:0]  rec_chan;
  logic [31:0]  w[4];                  // base frame words
  logic [132:0] r;                     // result taken by the receiver
  int           fails, num_checks;

  ssel_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_wdat), .wb_sel_i(wb_sel), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .in_valid_i(in_valid), .in_ready_o(in_ready), .in_data_i(in_data),
    .in_last_i(in_last), .ctl_valid_i(ctl_valid), .ctl_out_i(ctl_out), .ctl_chan_i(ctl_chan),
    .ctl_sub_i(ctl_sub), .out_valid_o(out_valid), .out_ready_i(out_ready),
    .selected_channel_outputs_o(out_data), .out_logic_o(out_logic), .out_store_o(out_store),
    .rec_sel_valid_o(rec_valid), .rec_sel_chan_o(rec_chan));
  ssel_sink_model u_snk (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
    .valid_i(out_valid), .ready_o(out_ready), .data_i(out_data), .logic_i(out_logic),
    .store_i(out_store));

  // 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // verdict and end of run
  task automatic summarize;
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // compare: case inequality so an unknown never matches
  task automatic chk(input string what, input logic [132:0] seen, input logic [132:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a wait that ran out counts as a mismatch and ends the run
  task automatic timeout(input string what);
    fails++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    summarize();
  endtask
  // classic single bus cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    wb_sel  <= sel;
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (n == 16) timeout("bus ack");
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // the four selection registers in one go
  task automatic sels(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c, input logic [31:0] d);
    wb(1'b1, 8'h04, a, 4'hf);
    wb(1'b1, 8'h08, b, 4'hf);
    wb(1'b1, 8'h0c, c, 4'hf);
    wb(1'b1, 8'h10, d, 4'hf);
  endtask
  // one four-word frame, each word mixed with x; words may stall
  task automatic send(input logic [31:0] x);
    int i;
    int n;
    @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      in_valid <= 1'b1;
      in_data  <= w[i] ^ x;
      in_last  <= (i == 3);
      for (n = 0; n < 64; n++) begin
        @(posedge clk_i);
        if (in_ready === 1'b1) break;
      end
      if (n == 64) timeout("stream ready");
    end
    in_valid <= 1'b0;
    in_last  <= 1'b0;
  endtask
  // next result accepted by the receiver model
  task automatic take;
    int n;
    for (n = 0; n < 64 && u_snk.got_q.size() == 0; n++) @(posedge clk_i);
    if (n == 64) timeout("frame result");
    r = u_snk.got_q.pop_front();
  endtask
  // whole-channel expectation for selections 2,0,1,3 with storage on
  function automatic logic [132:0] whole(input logic [31:0] x);
    return {1'b1, 4'h0, w[3] ^ x, w[1] ^ x, w[0] ^ x, w[2] ^ x};
  endfunction

  // reset values and an unmapped read
  task automatic t_reset;
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk("ctrl reset", rd, 32'h0804_0300);
    wb(1'b0, 8'h04, 32'h0, 4'hf);
    chk("sel0 reset", rd, 32'h0);
    wb(1'b0, 8'h18, 32'h0, 4'hf);
    chk("unmapped read", rd, 32'h0);
  endtask
  // whole channels; logic stays low in whole mode
  task automatic t_whole;
    wb(1'b1, 8'h00, 32'h0804_0328, 4'hf);
    sels(32'h0000_0002, 32'h0000_0000, 32'h0000_0001, 32'h0000_0003);
    send(32'h0);
    take();
    chk("whole frame", r, whole(32'h0));
  endtask
  // 8-bit packed fields, low field first, compare outputs
  task automatic t_packed;
    wb(1'b1, 8'h00, 32'h0804_030b, 4'hf);
    sels(32'h0011_0000, 32'h0065_0005, 32'h0000_000f, 32'h00bb_000a);
    send(32'h0);
    take();
    chk("packed frame", r, {1'b0, 4'b1101, 32'hbb, 32'h00, 32'h66, 32'h11});
  endtask
  // sub-fields of 8 bits, four per channel; index 4 is out of range
  task automatic t_sub;
    wb(1'b1, 8'h00, 32'h0804_030d, 4'hf);
    sels(32'h0077_0201, 32'h0000_0003, 32'h0044_0300, 32'h0000_0402);
    send(32'h0);
    take();
    chk("sub frame", r, {1'b0, 4'b1101, 32'h0, 32'h44, 32'hdd, 32'h77});
  endtask
  // float stream: packed mode bits set but whole channels used
  task automatic t_float;
    wb(1'b1, 8'h00, 32'h0804_030a, 4'hf);
    send(32'h0);
    take();
    chk("float frame", r, {1'b0, 4'h0, w[2], w[0], w[3], w[1]});
  endtask
  // control input drives selection; byte write merges into ctrl
  task automatic t_ctl;
    wb(1'b1, 8'h00, 32'h0000_0050, 4'h1);
    wb(1'b0, 8'h00, 32'h0, 4'hf);
    chk("ctrl merge", rd, 32'h0804_0350);
    @(posedge clk_i);
    ctl_valid <= 1'b1;
    ctl_out   <= 2'h2;
    ctl_chan  <= 8'h07;
    ctl_sub   <= 8'h00;
    @(posedge clk_i);
    ctl_valid <= 1'b0;
    @(negedge clk_i);
    chk("sel record pulse", rec_valid, 1'b1);
    chk("sel record value", rec_chan, 32'h0207_0301);
    wb(1'b1, 8'h0c, 32'h0044_0005, 4'hf);
    wb(1'b0, 8'h0c, 32'h0, 4'hf);
    chk("sel2 after control", rd, 32'h0044_0007);
  endtask
  // receiver stalls: buffer fills, refuses, then drains in order
  task automatic t_buf;
    int k;
    wb(1'b1, 8'h00, 32'h0804_0328, 4'hf);
    sels(32'h0000_0002, 32'h0000_0000, 32'h0000_0001, 32'h0000_0003);
    stall <= 1'b1;
    send(32'h1);
    send(32'h2);
    repeat (3) @(posedge clk_i);
    chk("ready when full", in_ready, 1'b0);
    wb(1'b0, 8'h14, 32'h0, 4'hf);
    chk("status when full", rd, 32'h0006_0001);
    stall <= 1'b0;
    slow  <= 1'b1;
    send(32'h3);
    for (k = 1; k <= 3; k++) begin
      take();
      chk("buffered frame", r, whole(k));
    end
  endtask

  // main sequence
  initial begin
    w[0] = 32'h4433_2211;
    w[1] = 32'h8877_6655;
    w[2] = 32'hccbb_aa99;
    w[3] = 32'h00ff_eedd;
    fails = 0;
    num_checks = 0;
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} = '0;
    {in_valid, in_last, in_data, ctl_valid, ctl_out, ctl_chan, ctl_sub, stall, slow} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_whole();
    t_packed();
    t_sub();
    t_float();
    t_ctl();
    t_buf();
    summarize();
  end
endmodule
